/* rtl/pcicsr_pkg.sv */
package pcicsr_pkg;

  // configuration byte offsets of the 16-bit registers
  localparam logic [7:0]  OFF_DEVICE_IDENTIFICATION     = 8'h02;
  localparam logic [7:0]  OFF_COMMAND       = 8'h04;
  localparam logic [7:0]  OFF_STATUS        = 8'h06;

  // dword index of each configuration word
  localparam logic [5:0]  DW_ID             = 6'(OFF_DEVICE_IDENTIFICATION >> 2);
  localparam logic [5:0]  DW_CMD_STS        = 6'(OFF_COMMAND >> 2);

  // command register bit positions
  localparam int          CMD_IO_BIT        = 0;
  localparam int          CMD_MEM_BIT       = 1;
  localparam int          CMD_MASTER_BIT    = 2;
  localparam int          CMD_SPECIAL_BIT   = 3;
  localparam int          CMD_MWI_BIT       = 4;
  localparam int          CMD_PALETTE_BIT   = 5;
  localparam int          CMD_PERR_BIT      = 6;
  localparam int          CMD_STEP_BIT      = 7;
  localparam int          CMD_SERR_BIT      = 8;
  localparam int          CMD_FBB_BIT       = 9;

  // status register bit positions
  localparam int          STS_MASTER_DATA_PARITY_FLAG_BIT   = 8;
  localparam int          STS_TABORT_S_BIT  = 11;
  localparam int          STS_TABORT_R_BIT  = 12;
  localparam int          STS_GOT_MASTER_ABORT_BIT    = 13;
  localparam int          STS_SYSERR_BIT    = 14;
  localparam int          STS_PARERR_BIT    = 15;

  localparam logic [15:0] CMD_RESET         = 16'h0000;
  localparam logic [15:0] CMD_WRITE_MASK    = 16'h0156;
  localparam logic [15:0] STS_RESET         = 16'h0210;
  localparam logic [15:0] STS_FIXED         = 16'h0210;
  localparam logic [15:0] STS_RCU_MASK      = 16'hf900;

  // bus command codes for master writes
  localparam logic [3:0]  BUS_CMD_MEM_WRITE = 4'h7;
  localparam logic [3:0]  BUS_CMD_MWI       = 4'hf;

endpackage : pcicsr_pkg

/* rtl/pcicsr_flags.sv */
`timescale 1ns/1ps

module pcicsr_flags
(
  input  wire logic        clk,      // clock
  input  wire logic        rst_b,    // sync reset, active low
  input  wire logic        ce,       // clock enable
  input  wire logic [15:0] set_evt,  // hardware set events
  input  wire logic [15:0] clr_w1c,  // write-one-to-clear strobes
  output logic      [15:0] flags     // sticky flag vector
);

  typedef struct packed
  {
    logic [15:0] flag;
  } pcicsr_flags_type;

  pcicsr_flags_type state;
  pcicsr_flags_type next_state;
  logic [15:0]      next_bit;

  genvar b;
  generate
    for (b = 0; b < 16; b++)
    begin : g_bit
      if (pcicsr_pkg::STS_RCU_MASK[b])
      begin : g_rcu
        // a set in the clearing cycle wins
        assign next_bit[b] = set_evt[b] | (state.flag[b] & ~clr_w1c[b]);
      end
      else
      begin : g_fixed
        assign next_bit[b] = pcicsr_pkg::STS_FIXED[b];
      end
    end
  endgenerate

  always_comb
  begin
    next_state = state;
    if (ce)
    begin
      next_state.flag = next_bit;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state.flag <= pcicsr_pkg::STS_RESET;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign flags = state.flag;

  a_flag_set_wins: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && (set_evt & pcicsr_pkg::STS_RCU_MASK) != 16'h0000)
    |=> ((flags & $past(set_evt) & pcicsr_pkg::STS_RCU_MASK)
         == ($past(set_evt) & pcicsr_pkg::STS_RCU_MASK)))
    else $error("sticky flag lost a set event");

  a_flag_zero_keeps: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && (clr_w1c & pcicsr_pkg::STS_RCU_MASK) == 16'h0000)
    |=> ((flags & $past(flags) & pcicsr_pkg::STS_RCU_MASK)
         == ($past(flags) & pcicsr_pkg::STS_RCU_MASK)))
    else $error("flag dropped without a clear");

endmodule : pcicsr_flags

/* rtl/pcicsr_top.sv */
`timescale 1ns/1ps

module pcicsr_top
#(
  parameter logic [15:0] DEVICE_IDENTIFICATION_CODE = 16'h5a01, // arbitrary value
  parameter logic [15:0] VENDOR_CODE    = 16'h5a00  // arbitrary value
)
(
  input  wire logic        clk,             // 100 MHz clock
  input  wire logic        rst_b,           // sync reset, active low
  input  wire logic        ce,              // clock enable
  input  wire logic        cfg_rd,          // config read strobe
  input  wire logic        cfg_wr,          // config write strobe
  input  wire logic [7:0]  cfg_addr,        // config byte address
  input  wire logic [3:0]  cfg_be,          // byte enables
  input  wire logic [31:0] cfg_wdata,       // config write data
  output logic      [31:0] cfg_rdata,       // config read data
  output logic             cfg_rvalid,      // read data valid pulse
  input  wire logic        mem_hit,         // memory cycle decoded
  output logic             mem_claim,       // claim memory cycle
  input  wire logic        io_hit,          // io cycle seen
  output logic             io_claim,        // claim io cycle
  input  wire logic        special_hit,     // special cycle seen
  output logic             special_claim,   // accept special cycle
  input  wire logic        mst_req,         // master wants the bus
  input  wire logic        mst_write,       // request is a write
  input  wire logic        mst_line_write,  // request is a full line
  output logic             mst_go,          // master start allowed
  output logic             mst_fast_b2b,    // fast back-to-back allowed
  output logic      [3:0]  mst_cmd,         // bus command for master
  input  wire logic        addr_detected_parity_error,    // address parity error seen
  input  wire logic        data_detected_parity_error,    // data parity error seen
  input  wire logic        perr_seen,       // parity error line asserted
  input  wire logic        mst_data_phase,  // we are master in data phase
  input  wire logic        perr_req,        // logic wants parity error
  input  wire logic        got_master_abort_evt,      // own cycle master aborted
  input  wire logic        tabort_rcv_evt,  // own cycle target aborted
  input  wire logic        tabort_snd_evt,  // we signalled target abort
  input  wire logic        perr_i,          // parity error pin in
  output logic             perr_o,          // parity error pin out
  output logic             perr_oe,         // parity error pin enable
  input  wire logic        serr_i,          // system error pin in
  output logic             serr_o,          // system error pin out
  output logic             serr_oe,         // system error pin enable
  output logic      [15:0] command_word,    // command register value
  output logic      [15:0] status_word      // status register value
);

  typedef struct packed
  {
    logic        system_error_driver_enable;
    logic        parity_error_response_enable;
    logic        write_invalidate_enable;
    logic        bus_initiator_enable;
    logic        memory_space_response_enable;
    logic [31:0] rdata;
    logic        rvalid;
    logic        serr_drive;
    logic        perr_drive;
  } pcicsr_top_type;

  pcicsr_top_type state;
  pcicsr_top_type next_state;

  logic [15:0] bus_command_control;
  logic [15:0] bus_error_status;
  logic [15:0] device_identification;
  logic [15:0] sts_set;
  logic [15:0] sts_clr;
  logic        cmd_sts_sel;
  logic        id_sel;
  logic        serr_fire;
  logic        perr_fire;

  assign device_identification = DEVICE_IDENTIFICATION_CODE;
  assign id_sel      = (cfg_addr[7:2] == pcicsr_pkg::DW_ID);
  assign cmd_sts_sel = (cfg_addr[7:2] == pcicsr_pkg::DW_CMD_STS);

  // only writable bits come from flops; the rest stay zero
  always_comb
  begin
    bus_command_control = pcicsr_pkg::CMD_RESET;
    bus_command_control[pcicsr_pkg::CMD_SERR_BIT]   = state.system_error_driver_enable;
    bus_command_control[pcicsr_pkg::CMD_PERR_BIT]   = state.parity_error_response_enable;
    bus_command_control[pcicsr_pkg::CMD_MWI_BIT]    = state.write_invalidate_enable;
    bus_command_control[pcicsr_pkg::CMD_MASTER_BIT] = state.bus_initiator_enable;
    bus_command_control[pcicsr_pkg::CMD_MEM_BIT]    = state.memory_space_response_enable;
  end

  assign serr_fire = addr_detected_parity_error & state.system_error_driver_enable;
  assign perr_fire = perr_req & state.parity_error_response_enable;

  // hardware events feeding the sticky status bits
  always_comb
  begin
    sts_set = 16'h0000;
    sts_set[pcicsr_pkg::STS_PARERR_BIT]   = addr_detected_parity_error | data_detected_parity_error;
    sts_set[pcicsr_pkg::STS_SYSERR_BIT]   = state.serr_drive &
                                            state.system_error_driver_enable;
    sts_set[pcicsr_pkg::STS_GOT_MASTER_ABORT_BIT]   = got_master_abort_evt;
    sts_set[pcicsr_pkg::STS_TABORT_R_BIT] = tabort_rcv_evt;
    sts_set[pcicsr_pkg::STS_TABORT_S_BIT] = tabort_snd_evt;
    sts_set[pcicsr_pkg::STS_MASTER_DATA_PARITY_FLAG_BIT]  = perr_seen & mst_data_phase &
                                            state.parity_error_response_enable;
  end

  // write one to clear, per byte lane of the upper half
  always_comb
  begin
    sts_clr = 16'h0000;
    if (cfg_wr && cmd_sts_sel)
    begin
      if (cfg_be[2])
      begin
        sts_clr[7:0] = cfg_wdata[23:16];
      end
      if (cfg_be[3])
      begin
        sts_clr[15:8] = cfg_wdata[31:24];
      end
    end
  end

  pcicsr_flags u_flags
  (
    .clk     (clk),
    .rst_b   (rst_b),
    .ce      (ce),
    .set_evt (sts_set),
    .clr_w1c (sts_clr),
    .flags   (bus_error_status)
  );

  always_comb
  begin
    next_state        = state;
    next_state.rvalid = 1'b0;
    if (ce)
    begin
      next_state.serr_drive = serr_fire;
      next_state.perr_drive = perr_fire;
      if (cfg_wr && cmd_sts_sel && cfg_be[0])
      begin
        // read-only bits of the low byte are dropped here
        next_state.parity_error_response_enable =
          cfg_wdata[pcicsr_pkg::CMD_PERR_BIT];
        next_state.write_invalidate_enable =
          cfg_wdata[pcicsr_pkg::CMD_MWI_BIT];
        next_state.bus_initiator_enable =
          cfg_wdata[pcicsr_pkg::CMD_MASTER_BIT];
        next_state.memory_space_response_enable =
          cfg_wdata[pcicsr_pkg::CMD_MEM_BIT];
      end
      if (cfg_wr && cmd_sts_sel && cfg_be[1])
      begin
        next_state.system_error_driver_enable =
          cfg_wdata[pcicsr_pkg::CMD_SERR_BIT];
      end
      if (cfg_rd)
      begin
        next_state.rvalid = 1'b1;
        if (id_sel)
        begin
          next_state.rdata = {device_identification, VENDOR_CODE};
        end
        else if (cmd_sts_sel)
        begin
          next_state.rdata = {bus_error_status, bus_command_control};
        end
        else
        begin
          next_state.rdata = 32'h0000_0000;
        end
      end
    end
    else
    begin
      next_state.rvalid = state.rvalid;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state.system_error_driver_enable   <= pcicsr_pkg::CMD_RESET[pcicsr_pkg::CMD_SERR_BIT];
      state.parity_error_response_enable <= pcicsr_pkg::CMD_RESET[pcicsr_pkg::CMD_PERR_BIT];
      state.write_invalidate_enable      <= pcicsr_pkg::CMD_RESET[pcicsr_pkg::CMD_MWI_BIT];
      state.bus_initiator_enable         <= pcicsr_pkg::CMD_RESET[pcicsr_pkg::CMD_MASTER_BIT];
      state.memory_space_response_enable <= pcicsr_pkg::CMD_RESET[pcicsr_pkg::CMD_MEM_BIT];
      state.rdata                        <= 32'h0000_0000;
      state.rvalid                       <= 1'b0;
      state.serr_drive                   <= 1'b0;
      state.perr_drive                   <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign cfg_rdata     = state.rdata;
  assign cfg_rvalid    = state.rvalid & ce;
  assign mem_claim     = mem_hit & state.memory_space_response_enable;
  assign io_claim      = io_hit & bus_command_control[pcicsr_pkg::CMD_IO_BIT];
  assign special_claim = special_hit &
                         bus_command_control[pcicsr_pkg::CMD_SPECIAL_BIT];
  assign mst_go        = mst_req & state.bus_initiator_enable;
  assign mst_fast_b2b  = bus_command_control[pcicsr_pkg::CMD_FBB_BIT];
  assign mst_cmd       = (mst_write && mst_line_write && state.write_invalidate_enable)
                         ? pcicsr_pkg::BUS_CMD_MWI
                         : pcicsr_pkg::BUS_CMD_MEM_WRITE;
  // open-drain pins: drive low while enabled
  assign serr_o        = 1'b0;
  assign serr_oe       = state.serr_drive;
  assign perr_o        = 1'b0;
  assign perr_oe       = state.perr_drive;
  assign command_word  = bus_command_control;
  assign status_word   = bus_error_status;

  a_id_read_fixed: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && cfg_rd && id_sel) |=> (cfg_rdata[31:16] == DEVICE_IDENTIFICATION_CODE))
    else $error("device_identification read wrong");

  a_cmd_ro_zero: assert property (@(posedge clk) disable iff (!rst_b)
    (command_word & ~pcicsr_pkg::CMD_WRITE_MASK) == 16'h0000)
    else $error("read-only command bit nonzero");

  a_no_fast_b2b: assert property (@(posedge clk) disable iff (!rst_b)
    !mst_fast_b2b && !command_word[pcicsr_pkg::CMD_FBB_BIT])
    else $error("fast back-to-back enabled");

  a_serr_gated: assert property (@(posedge clk) disable iff (!rst_b)
    serr_oe |-> ($past(ce) ? $past(addr_detected_parity_error && state.system_error_driver_enable)
                           : $past(serr_oe)))
    else $error("system error driven without enable");

  a_perr_gated: assert property (@(posedge clk) disable iff (!rst_b)
    perr_oe |-> ($past(ce) ? $past(perr_req && command_word[pcicsr_pkg::CMD_PERR_BIT])
                           : $past(perr_oe)))
    else $error("parity error driven without enable");

  a_mwi_select: assert property (@(posedge clk) disable iff (!rst_b)
    (mst_cmd == pcicsr_pkg::BUS_CMD_MWI)
    |-> (command_word[pcicsr_pkg::CMD_MWI_BIT] && mst_write))
    else $error("write-invalidate used while disabled");

  a_master_gate: assert property (@(posedge clk) disable iff (!rst_b)
    mst_go |-> (mst_req && command_word[pcicsr_pkg::CMD_MASTER_BIT]))
    else $error("master started while disabled");

  a_mem_gate: assert property (@(posedge clk) disable iff (!rst_b)
    mem_claim == (mem_hit && command_word[pcicsr_pkg::CMD_MEM_BIT]))
    else $error("memory claim mismatch");

  a_io_never: assert property (@(posedge clk) disable iff (!rst_b)
    !io_claim && !special_claim)
    else $error("io or special cycle claimed");

  a_parerr_sets: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && (addr_detected_parity_error || data_detected_parity_error)) |=> status_word[pcicsr_pkg::STS_PARERR_BIT])
    else $error("parity error flag not set");

  a_syserr_follows: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && serr_fire) ##1 (ce && command_word[pcicsr_pkg::CMD_SERR_BIT])
    |=> status_word[pcicsr_pkg::STS_SYSERR_BIT])
    else $error("system error flag not set");

  a_aborts_set: assert property (@(posedge clk) disable iff (!rst_b)
    (ce && (got_master_abort_evt || tabort_rcv_evt || tabort_snd_evt))
    |=> (({status_word[pcicsr_pkg::STS_GOT_MASTER_ABORT_BIT],
           status_word[pcicsr_pkg::STS_TABORT_R_BIT],
           status_word[pcicsr_pkg::STS_TABORT_S_BIT]}
          & $past({got_master_abort_evt, tabort_rcv_evt, tabort_snd_evt}))
         == $past({got_master_abort_evt, tabort_rcv_evt, tabort_snd_evt})))
    else $error("abort flags not set");

  a_master_data_parity_flag_cond: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(status_word[pcicsr_pkg::STS_MASTER_DATA_PARITY_FLAG_BIT])
    |-> $past(perr_seen && mst_data_phase && command_word[pcicsr_pkg::CMD_PERR_BIT]))
    else $error("data parity flag set without cause");

  a_status_fixed: assert property (@(posedge clk) disable iff (!rst_b)
    (status_word & ~pcicsr_pkg::STS_RCU_MASK) == pcicsr_pkg::STS_FIXED)
    else $error("fixed status bits changed");

  c_mem_enable: cover property (@(posedge clk) disable iff (!rst_b)
    (cfg_wr && cmd_sts_sel && cfg_be[0] && cfg_wdata[pcicsr_pkg::CMD_MEM_BIT]) ##1 mem_claim);
  c_w1c_clear: cover property (@(posedge clk) disable iff (!rst_b)
    status_word[pcicsr_pkg::STS_GOT_MASTER_ABORT_BIT] ##1 !status_word[pcicsr_pkg::STS_GOT_MASTER_ABORT_BIT]);
  c_serr_drive: cover property (@(posedge clk) disable iff (!rst_b) serr_oe);
  c_mwi_used: cover property (@(posedge clk) disable iff (!rst_b)
    mst_go && mst_cmd == pcicsr_pkg::BUS_CMD_MWI);

endmodule : pcicsr_top

/* bench/pcicsr_agent_model.sv */
`timescale 1ns/1ps

// another bus agent sharing the open-drain error wires, both held high by pull-ups
module pcicsr_agent_model
(
  input  wire logic perr_o,     // device parity error drive level
  input  wire logic perr_oe,    // device parity error drive enable
  input  wire logic serr_o,     // device system error drive level
  input  wire logic serr_oe,    // device system error drive enable
  input  wire logic agent_perr, // this agent reports a parity error
  output logic      perr_line,  // resolved parity error wire
  output logic      serr_line,  // resolved system error wire
  output logic      perr_seen   // parity error wire pulled low by anyone
);
  assign perr_line = (perr_oe ? perr_o : 1'b1) & ~agent_perr;
  assign serr_line = serr_oe ? serr_o : 1'b1;
  assign perr_seen = ~perr_line;
endmodule : pcicsr_agent_model

/* bench/tb_top.sv */
`timescale 1ns/1ps

`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end

module tb_top;
  localparam logic [15:0] ID_CODE  = 16'h3c71; // arbitrary value
  localparam logic [15:0] VEN_CODE = 16'h3c70; // arbitrary value
  logic        clk = 1'b0, rst_b = 1'b0, ce = 1'b1, cfg_rd = 1'b0, cfg_wr = 1'b0;
  logic [7:0]  cfg_addr = 8'h00;
  logic [3:0]  cfg_be = 4'h0;
  logic [31:0] cfg_wdata = 32'h0;
  logic        mem_hit = 1'b0, io_hit = 1'b0, special_hit = 1'b0;
  logic        mst_req = 1'b0, mst_write = 1'b0, mst_line_write = 1'b0;
  logic [7:0]  ev = 8'h00;
  logic [31:0] cfg_rdata;
  logic [15:0] command_word, status_word;
  logic [3:0]  mst_cmd;
  logic        cfg_rvalid, mem_claim, io_claim, special_claim, mst_go, mst_fast_b2b;
  logic        perr_o, perr_oe, serr_o, serr_oe, perr_line, serr_line, perr_seen;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  pcicsr_top #(.DEVICE_IDENTIFICATION_CODE(ID_CODE), .VENDOR_CODE(VEN_CODE)) pcicsr_top_i
  (
    .clk(clk), .rst_b(rst_b), .ce(ce), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .mem_hit(mem_hit), .mem_claim(mem_claim), .io_hit(io_hit),
    .io_claim(io_claim), .special_hit(special_hit), .special_claim(special_claim),
    .mst_req(mst_req), .mst_write(mst_write), .mst_line_write(mst_line_write),
    .mst_go(mst_go), .mst_fast_b2b(mst_fast_b2b), .mst_cmd(mst_cmd),
    .addr_detected_parity_error(ev[0]), .data_detected_parity_error(ev[1]), .perr_seen(perr_seen),
    .mst_data_phase(ev[7]), .perr_req(ev[5]), .got_master_abort_evt(ev[2]),
    .tabort_rcv_evt(ev[3]), .tabort_snd_evt(ev[4]), .perr_i(perr_line),
    .perr_o(perr_o), .perr_oe(perr_oe), .serr_i(serr_line), .serr_o(serr_o),
    .serr_oe(serr_oe), .command_word(command_word), .status_word(status_word)
  );

  pcicsr_agent_model pcicsr_agent_model_i
  (
    .perr_o(perr_o), .perr_oe(perr_oe), .serr_o(serr_o), .serr_oe(serr_oe),
    .agent_perr(ev[6]), .perr_line(perr_line), .serr_line(serr_line),
    .perr_seen(perr_seen)
  );

  initial
  begin
    forever #5 clk = ~clk;
  end

  function automatic logic [15:0] exp_cmd(input logic [15:0] old, input logic [1:0] b,
                                          input logic [15:0] d);
    logic [15:0] r;
    r = old;
    if (b[0])
      r[7:0] = d[7:0] & 8'h56;
    if (b[1])
      r[15:8] = d[15:8] & 8'h01;
    return r;
  endfunction : exp_cmd

  task automatic cfg_write(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge clk);
    cfg_wr    <= 1'b1;
    cfg_addr  <= a;
    cfg_be    <= b;
    cfg_wdata <= d;
    @(posedge clk);
    cfg_wr <= 1'b0;
    #1;
  endtask : cfg_write

  task automatic cfg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    cfg_rd   <= 1'b1;
    cfg_addr <= a;
    @(posedge clk);
    cfg_rd <= 1'b0;
    #1;
    `CHK(cfg_rvalid, 1'b1)
    d = cfg_rdata;
  endtask : cfg_read

  task automatic pulse(input logic [7:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 8'h00;
    #1;
  endtask : pulse

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  // cut a hang short
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      n_fail++;
      end_of_test();
    end
  end

  initial
  begin
    logic [31:0] rd;
    logic [15:0] cmd;
    logic [15:0] wd;
    logic [3:0]  be;
    int          bitpos [5];
    void'($urandom(32'ha943));
    bitpos = '{15, 15, 13, 12, 11};
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    #1;
    `CHK(command_word, 16'h0000)
    `CHK(status_word, 16'h0210)
    cfg_write(8'h00, 4'hf, 32'hffff_ffff);
    cfg_read(8'h02, rd);
    `CHK(rd, {ID_CODE, VEN_CODE})
    cfg_read(8'h08, rd);
    `CHK(rd, 32'h0000_0000)
    cmd = 16'h0000;
    for (int n = 0; n < 40; n++)
    begin
      wd = (n < 2) ? {16{n[0]}} : 16'($urandom);
      be = (n < 2) ? 4'h3 : 4'($urandom);
      cfg_write(8'h04, be, {16'($urandom), wd});
      cmd = exp_cmd(cmd, be[1:0], wd);
      `CHK(command_word, cmd)
      @(posedge clk);
      {mem_hit, io_hit, special_hit, mst_req, mst_write, mst_line_write} <= 6'($urandom);
      #1;
      `CHK(mem_claim, mem_hit & cmd[1])
      `CHK(io_claim, 1'b0)
      `CHK(special_claim, 1'b0)
      `CHK(mst_go, mst_req & cmd[2])
      `CHK(mst_fast_b2b, 1'b0)
      `CHK(mst_cmd, (mst_write & mst_line_write & cmd[4]) ? 4'hf : 4'h7)
      cfg_read(8'h04, rd);
      `CHK(rd, {16'h0210, cmd})
    end
    // frozen while the clock enable is low
    cfg_write(8'h04, 4'h3, 32'h0);
    @(posedge clk);
    ce <= 1'b0;
    pulse(8'h04);
    @(posedge clk);
    ce <= 1'b1;
    #1;
    `CHK(status_word, 16'h0210)
    for (int i = 0; i < 5; i++)
    begin
      pulse(8'(1 << i));
      `CHK(serr_oe, 1'b0)
      `CHK(status_word, 16'h0210 | (16'h1 << bitpos[i]))
      cfg_write(8'h04, 4'hc, 32'h0);
      `CHK(status_word, 16'h0210 | (16'h1 << bitpos[i]))
      cfg_write(8'h04, 4'hc, {16'h1 << bitpos[i], 16'h0000});
      `CHK(status_word, 16'h0210)
    end
    cfg_write(8'h04, 4'h3, 32'h0000_0140);
    pulse(8'h01);
    `CHK(serr_oe, 1'b1)
    `CHK(serr_o, 1'b0)
    `CHK(serr_line, 1'b0)
    @(posedge clk);
    #1;
    `CHK(status_word[15:14], 2'b11)
    pulse(8'h20);
    `CHK(perr_oe, 1'b1)
    `CHK(perr_o, 1'b0)
    `CHK(perr_line, 1'b0)
    pulse(8'h40);
    `CHK(status_word[8], 1'b0)
    pulse(8'hc0);
    `CHK(status_word[8], 1'b1)
    // set and clear of one flag in the same cycle
    @(posedge clk);
    ev        <= 8'h04;
    cfg_wr    <= 1'b1;
    cfg_addr  <= 8'h04;
    cfg_be    <= 4'h8;
    cfg_wdata <= 32'h2000_0000;
    @(posedge clk);
    ev     <= 8'h00;
    cfg_wr <= 1'b0;
    #1;
    `CHK(status_word[13], 1'b1)
    cfg_write(8'h04, 4'hf, 32'he100_0000);
    `CHK(status_word, 16'h0210)
    `CHK(command_word, 16'h0000)
    pulse(8'hc0);
    `CHK(status_word[8], 1'b0)
    pulse(8'h20);
    `CHK(perr_oe, 1'b0)
    pulse(8'h01);
    `CHK(serr_oe, 1'b0)
    @(posedge clk);
    #1;
    `CHK(status_word[14], 1'b0)
    end_of_test();
  end
endmodule : tb_top
